/* logic/pri_ctrl.sv */
// Priority interrupt controller top: registers, CPU request path and save stack
// Summary of operation
// - Unacked flag set while a pending request is held off by CPU level.
// - Hold bit one: captured vector follows highest pending interrupt.
// - Hold bit zero: captured vector keeps last acknowledged interrupt.
// - Four-bit new CPU level field reports levels 0 to 15.
// - Captured vector sits in bits 6:0, values 0 to 118.
// - Unused test register bits read zero and ignore writes.
// - Reset puts every user source priority at level 4.
// - Priority 000 disables a source; 111 is highest user level 7.
// - Nesting disable bit 15 stops handlers being preempted by user sources.
// - A source requests only with both flag and enable set.
// - Return restores saved status byte and previous CPU level.
// - ORing 0Eh into status byte raises CPU levels 0-7 to 7 and levels 8-15 to 15.
// - Traps at levels 12-15 are masked only by CPU level, never by nesting or timed disable.
// - Timed disable masks levels 1-6 for a count; level 7 still passes.
//
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/10ps
`default_nettype none
module pri_ctrl #(
   parameter int NUM_SRC     = 8,
   parameter int NUM_TRAP    = 4,
   parameter int STACK_DEPTH = 16
) (
   input  wire logic                        REF_CLK,
   input  wire logic                        RST,
   input  wire logic [pri_pkg::ADDR_W-1:0]  ADDR,
   input  wire logic [pri_pkg::DATA_W-1:0]  WDATA,
   input  wire logic                        WR,
   input  wire logic                        RD,
   output logic      [pri_pkg::DATA_W-1:0]  RDATA,
   input  wire logic [NUM_SRC-1:0]          SRC_EVENT,
   input  wire logic [NUM_TRAP-1:0]         TRAP_EVENT,
   output logic                             CPU_IRQ,
   output logic      [pri_pkg::VEC_W-1:0]   CPU_VECTOR,
   output logic      [pri_pkg::LVL_W-1:0]   CPU_LEVEL,
   input  wire logic                        CPU_ACK,
   input  wire logic                        CPU_RETURN,
   output logic                             INT
);
   import pri_pkg::*;
   localparam int NPR = NUM_SRC / PRIO_PER_REG;
   localparam int SW  = LVL_W + 8;

   logic [NUM_TRAP-1:0]     trap_flag_r;
   logic                    nest_dis_r;
   logic [NUM_SRC-1:0]      flag_r;
   logic [NUM_SRC-1:0]      en_r;
   logic [PRIO_W-1:0]       prio_r [NUM_SRC];
   logic [NUM_SRC*PRIO_W-1:0] prio_flat;
   logic [LVL_W-1:0]        cpu_lvl_r;
   logic [7:0]              srl_r;
   logic                    hold_r;
   logic [VEC_W-1:0]        last_vec_r;
   logic [DATA_W-1:0]       timed_interrupt_disable_cnt_r;
   logic [EV_W-1:0]         istat_r;
   logic [EV_W-1:0]         imask_r;
   logic                    unack_r;
   logic [DATA_W-1:0]       rdata_nxt;
   logic                    any;
   logic [VEC_W-1:0]        best_vec;
   logic [LVL_W-1:0]        best_lvl;
   logic [LVL_W-1:0]        user_thr;
   logic                    irq;
   logic                    unack;
   logic                    take;
   logic                    stk_empty;
   logic [SW-1:0]           stk_top;
   logic [7:0]              srl_view;
   logic [VEC_W-1:0]        cap_vec;
   logic [EV_W-1:0]         ev;

   ////////////////////////////////////////////////////////////////////////////////
   // Control, flag and enable registers; a hardware set wins over a write
   always_ff @(posedge REF_CLK)
   begin
      if (RST)
      begin
         trap_flag_r <= '0;
         nest_dis_r  <= 1'b0;
      end
      else
      begin
         trap_flag_r <= ((WR && ADDR == OFF_CTRL1) ? WDATA[NUM_TRAP-1:0] : trap_flag_r)
                        | TRAP_EVENT;
         if (WR && ADDR == OFF_CTRL1)
            nest_dis_r <= WDATA[NEST_DIS_BIT];
      end
   end

   always_ff @(posedge REF_CLK)
   begin
      if (RST)
         flag_r <= '0;
      else
         flag_r <= ((WR && ADDR == OFF_FLAG) ? WDATA[NUM_SRC-1:0] : flag_r) | SRC_EVENT;
   end

   always_ff @(posedge REF_CLK)
   begin
      if (RST)
         en_r <= '0;
      else if (WR && ADDR == OFF_EN)
         en_r <= WDATA[NUM_SRC-1:0];
   end

   genvar s;
   generate
      for (s = 0; s < NUM_SRC; s++)
      begin : g_prio
         localparam logic [7:0] PADDR = OFF_PRIO0 + 8'((s / PRIO_PER_REG) * 2);
         always_ff @(posedge REF_CLK)
         begin
            if (RST)
               prio_r[s] <= PRIO_RST;
            else if (WR && ADDR == PADDR)
               prio_r[s] <= WDATA[(s % PRIO_PER_REG)*PRIO_STRIDE +: PRIO_W];
         end
         assign prio_flat[s*PRIO_W +: PRIO_W] = prio_r[s];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Arbitration against the CPU level
   pri_arbiter #(
      .NUM_SRC  (NUM_SRC),
      .NUM_TRAP (NUM_TRAP)
   ) u_arb (
      .src_prio (prio_flat),
      .src_req  (flag_r & en_r),
      .trap_req (trap_flag_r),
      .any      (any),
      .best_vec (best_vec),
      .best_lvl (best_lvl)
   );

   // User threshold is lifted by nesting disable and the timed disable
   always_comb
   begin
      user_thr = cpu_lvl_r;
      if (timed_interrupt_disable_cnt_r != '0 && user_thr < TIMED_INTERRUPT_DISABLE_LVL)
         user_thr = TIMED_INTERRUPT_DISABLE_LVL;
      if (nest_dis_r && !stk_empty)
         user_thr = USER_MAX_LVL;
   end

   // Traps compare only against the CPU level, never the user threshold
   assign irq   = any && ((best_lvl >= TRAP_LVL_MIN) ? (best_lvl > cpu_lvl_r)
                                                     : (best_lvl > user_thr));
   assign unack = any && !irq;
   assign take  = CPU_ACK && irq;

   assign CPU_IRQ    = irq;
   assign CPU_VECTOR = best_vec;
   assign CPU_LEVEL  = best_lvl;

   ////////////////////////////////////////////////////////////////////////////////
   // CPU level, status byte and save stack
   pri_level_stack #(
      .DEPTH     (STACK_DEPTH),
      .WIDTH     (SW)
   ) u_stk (
      .clk       (REF_CLK),
      .rst       (RST),
      .push      (take),
      .pop       (CPU_RETURN && !take),
      .push_data ({cpu_lvl_r, srl_view}),
      .top_data  (stk_top),
      .empty     (stk_empty),
      .full      ()
   );

   assign srl_view = {srl_r[7:4], cpu_lvl_r[2:0], srl_r[0]};

   always_ff @(posedge REF_CLK)
   begin
      if (RST)
      begin
         cpu_lvl_r <= '0;
         srl_r     <= '0;
      end
      else if (take)
         cpu_lvl_r <= best_lvl;
      else if (CPU_RETURN && !stk_empty)
      begin
         cpu_lvl_r <= stk_top[SW-1 -: LVL_W];
         srl_r     <= stk_top[7:0];
      end
      else if (WR && ADDR == OFF_SRL)
      begin
         // Level bits sit at 3:1 and level bit 3 is kept, so an OR of 0Eh lands on 7 below level 8, else on 15
         cpu_lvl_r <= {cpu_lvl_r[LVL_W-1], WDATA[SRL_LVL_LSB +: 3]};
         srl_r     <= WDATA[7:0];
      end
   end

   always_ff @(posedge REF_CLK)
   begin
      if (RST)
         last_vec_r <= '0;
      else if (take)
         last_vec_r <= best_vec;
   end

   always_ff @(posedge REF_CLK)
   begin
      if (RST)
         hold_r <= 1'b0;
      else if (WR && ADDR == OFF_TEST)
         hold_r <= WDATA[HOLD_BIT];
   end

   // Count of cycles left in a timed disable; zero means inactive
   always_ff @(posedge REF_CLK)
   begin
      if (RST)
         timed_interrupt_disable_cnt_r <= '0;
      else if (WR && ADDR == OFF_TIMED_INTERRUPT_DISABLE)
         timed_interrupt_disable_cnt_r <= WDATA;
      else if (timed_interrupt_disable_cnt_r != '0)
         timed_interrupt_disable_cnt_r <= timed_interrupt_disable_cnt_r - DATA_W'(1);
   end

   assign cap_vec = hold_r ? (any ? best_vec : '0) : last_vec_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Sticky events, cleared by reading; a new event in the read cycle survives
   assign ev = {unack && !unack_r, |TRAP_EVENT, take};

   always_ff @(posedge REF_CLK)
   begin
      if (RST)
      begin
         istat_r <= '0;
         imask_r <= '0;
         unack_r <= 1'b0;
      end
      else
      begin
         istat_r <= ((RD && ADDR == OFF_ISTAT) ? '0 : istat_r) | ev;
         unack_r <= unack;
         if (WR && ADDR == OFF_IMASK)
            imask_r <= WDATA[EV_W-1:0];
      end
   end

   assign INT = |(istat_r & imask_r);

   ////////////////////////////////////////////////////////////////////////////////
   // Read mux; unmapped addresses read zero
   always_comb
   begin
      rdata_nxt = '0;
      case (ADDR)
         OFF_CTRL1 :
         begin
            rdata_nxt[NEST_DIS_BIT]   = nest_dis_r;
            rdata_nxt[NUM_TRAP-1:0]   = trap_flag_r;
         end
         OFF_FLAG  : rdata_nxt[NUM_SRC-1:0] = flag_r;
         OFF_EN    : rdata_nxt[NUM_SRC-1:0] = en_r;
         OFF_SRL   : rdata_nxt[7:0] = srl_view;
         OFF_TEST  :
         begin
            rdata_nxt[UNACK_BIT]             = unack;
            rdata_nxt[HOLD_BIT]              = hold_r;
            rdata_nxt[LVL_LSB +: LVL_W]      = cpu_lvl_r;
            rdata_nxt[VEC_W-1:0]             = cap_vec;
         end
         OFF_ISTAT : rdata_nxt[EV_W-1:0] = istat_r;
         OFF_IMASK : rdata_nxt[EV_W-1:0] = imask_r;
         OFF_TIMED_INTERRUPT_DISABLE  : rdata_nxt = timed_interrupt_disable_cnt_r;
         default   :
         begin
            for (int r = 0; r < NPR; r++)
            begin
               if (ADDR == OFF_PRIO0 + 8'(r * 2))
               begin
                  for (int j = 0; j < PRIO_PER_REG; j++)
                     rdata_nxt[j*PRIO_STRIDE +: PRIO_W] = prio_r[r*PRIO_PER_REG + j];
               end
            end
         end
      endcase
   end

   always_ff @(posedge REF_CLK)
   begin
      if (RST)
         RDATA <= '0;
      else if (RD)
         RDATA <= rdata_nxt;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RST);

   property p_unack;
      (RD && ADDR == OFF_TEST) |=> RDATA[UNACK_BIT] == $past(any && !irq);
   endproperty
   a_unack : assert property (p_unack) else $error("unacked flag missing");

   property p_hold_one;
      (hold_r && any) |-> cap_vec == best_vec;
   endproperty
   a_hold_one : assert property (p_hold_one) else $error("vector not live");

   property p_hold_zero;
      (take && !hold_r) ##1 (!take && !hold_r) |-> cap_vec == $past(best_vec);
   endproperty
   a_hold_zero : assert property (p_hold_zero) else $error("vector not kept");

   property p_vec_range;
      cap_vec <= VEC_MAX;
   endproperty
   a_vec_range : assert property (p_vec_range) else $error("vector out of range");

   property p_zero_prio;
      (irq && best_lvl < TRAP_LVL_MIN) |-> best_lvl != '0;
   endproperty
   a_zero_prio : assert property (p_zero_prio) else $error("disabled source won");

   property p_nest;
      (nest_dis_r && !stk_empty && any && best_lvl < TRAP_LVL_MIN) |-> !irq;
   endproperty
   a_nest : assert property (p_nest) else $error("nested user request");

   property p_return;
      (CPU_RETURN && !take && !stk_empty) |=> cpu_lvl_r == $past(stk_top[SW-1 -: LVL_W]);
   endproperty
   a_return : assert property (p_return) else $error("level not restored");

   property p_trap;
      (any && best_lvl >= TRAP_LVL_MIN && best_lvl > cpu_lvl_r) |-> irq;
   endproperty
   a_trap : assert property (p_trap) else $error("trap masked");

   property p_timed_interrupt_disable;
      (timed_interrupt_disable_cnt_r != '0 && best_lvl <= TIMED_INTERRUPT_DISABLE_LVL) |-> !irq;
   endproperty
   a_timed_interrupt_disable : assert property (p_timed_interrupt_disable) else $error("timed disable leaked");

   property p_strict;
      irq |-> best_lvl > cpu_lvl_r;
   endproperty
   a_strict : assert property (p_strict) else $error("request not above level");

   c_take   : cover property (take ##[1:20] CPU_RETURN);
   c_nested : cover property (take && !stk_empty);
   c_unack  : cover property (unack && hold_r);
   c_timed_interrupt_disable   : cover property (timed_interrupt_disable_cnt_r != '0 && irq);
endmodule : pri_ctrl
`default_nettype wire

/* include/pri_pkg.sv */
// Constants, register offsets and field layout for the priority interrupt controller
package pri_pkg;
   localparam int          ADDR_W       = 8;
   localparam int          DATA_W       = 16;
   localparam int          LVL_W        = 4;
   localparam int          VEC_W        = 7;
   localparam int          PRIO_W       = 3;
   localparam int          EV_W         = 3;
   localparam int          PRIO_PER_REG = 4;
   localparam int          PRIO_STRIDE  = 4;
   // Register byte offsets, one 16-bit word each
   localparam logic [7:0]  OFF_CTRL1    = 8'h00;
   localparam logic [7:0]  OFF_FLAG     = 8'h02;
   localparam logic [7:0]  OFF_EN       = 8'h04;
   localparam logic [7:0]  OFF_PRIO0    = 8'h06;
   localparam logic [7:0]  OFF_PRIO_INC = 8'h02;
   localparam logic [7:0]  OFF_SRL      = 8'h20;
   localparam logic [7:0]  OFF_TEST     = 8'h22;
   localparam logic [7:0]  OFF_ISTAT    = 8'h24;
   localparam logic [7:0]  OFF_IMASK    = 8'h26;
   localparam logic [7:0]  OFF_TIMED_INTERRUPT_DISABLE     = 8'h28;
   // Field positions
   localparam int          NEST_DIS_BIT = 15;
   localparam int          UNACK_BIT    = 15;
   localparam int          HOLD_BIT     = 13;
   localparam int          LVL_LSB      = 8;
   localparam int          SRL_LVL_LSB  = 1;
   localparam int          EV_TAKEN     = 0;
   localparam int          EV_TRAP      = 1;
   localparam int          EV_UNACK     = 2;
   // Reset values and level encodings
   localparam logic [2:0]  PRIO_RST     = 3'h4;
   localparam logic [2:0]  PRIO_OFF     = 3'h0;
   localparam logic [3:0]  USER_MAX_LVL = 4'h7;
   localparam logic [3:0]  TIMED_INTERRUPT_DISABLE_LVL     = 4'h6;
   localparam logic [3:0]  TRAP_LVL_TOP = 4'hF;
   localparam logic [3:0]  TRAP_LVL_MIN = 4'h8;
   localparam logic [6:0]  SRC_VEC_BASE = 7'h08;
   localparam logic [6:0]  VEC_MAX      = 7'h76;
endpackage : pri_pkg

/* logic/pri_arbiter.sv */
// Highest-priority selection among pending traps and enabled user sources
`timescale 1ns/10ps
`default_nettype none
module pri_arbiter #(
   parameter int NUM_SRC  = 8,
   parameter int NUM_TRAP = 4
) (
   input  wire logic [NUM_SRC*pri_pkg::PRIO_W-1:0] src_prio,
   input  wire logic [NUM_SRC-1:0]                 src_req,
   input  wire logic [NUM_TRAP-1:0]                trap_req,
   output logic                                    any,
   output logic [pri_pkg::VEC_W-1:0]               best_vec,
   output logic [pri_pkg::LVL_W-1:0]               best_lvl
);
   import pri_pkg::*;
   localparam int NC = NUM_SRC + NUM_TRAP;

   logic [LVL_W-1:0] cand_lvl [NC];
   logic [VEC_W-1:0] cand_vec [NC];
   logic [NC-1:0]    cand_ok;

   ////////////////////////////////////////////////////////////////////////////////
   genvar k;
   generate
      for (k = 0; k < NC; k++)
      begin : g_cand
         if (k < NUM_TRAP)
         begin : g_trap
            assign cand_ok[k]  = trap_req[k];
            assign cand_lvl[k] = TRAP_LVL_TOP - LVL_W'(k);
            assign cand_vec[k] = VEC_W'(k);
         end
         else
         begin : g_src
            // Priority zero switches a source off entirely
            assign cand_ok[k]  = src_req[k-NUM_TRAP] &&
                                 (src_prio[(k-NUM_TRAP)*PRIO_W +: PRIO_W] != PRIO_OFF);
            assign cand_lvl[k] = {1'b0, src_prio[(k-NUM_TRAP)*PRIO_W +: PRIO_W]};
            assign cand_vec[k] = SRC_VEC_BASE + VEC_W'(k - NUM_TRAP);
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Strict compare keeps the lower vector on equal levels
   always_comb
   begin
      any      = 1'b0;
      best_lvl = '0;
      best_vec = '0;
      for (int i = 0; i < NC; i++)
      begin
         if (cand_ok[i] && (!any || cand_lvl[i] > best_lvl))
         begin
            any      = 1'b1;
            best_lvl = cand_lvl[i];
            best_vec = cand_vec[i];
         end
      end
   end
endmodule : pri_arbiter
`default_nettype wire

/* logic/pri_level_stack.sv */
// Save stack for CPU level and status byte across nested handlers
`timescale 1ns/10ps
`default_nettype none
module pri_level_stack #(
   parameter int DEPTH = 16,
   parameter int WIDTH = 12
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             push,
   input  wire logic             pop,
   input  wire logic [WIDTH-1:0] push_data,
   output logic      [WIDTH-1:0] top_data,
   output logic                  empty,
   output logic                  full
);
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [CW-1:0]    cnt_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Push beyond depth is dropped; the restore then gets the newest stored entry
   always_ff @(posedge clk)
   begin
      if (rst)
         cnt_r <= '0;
      else if (push && !full)
         cnt_r <= cnt_r + CW'(1);
      else if (pop && !empty)
         cnt_r <= cnt_r - CW'(1);
   end

   always_ff @(posedge clk)
   begin
      if (push && !full)
         mem[cnt_r[$clog2(DEPTH)-1:0]] <= push_data;
   end

   assign empty    = (cnt_r == '0);
   assign full     = (cnt_r == CW'(DEPTH));
   assign top_data = empty ? '0 : mem[$clog2(DEPTH)'(cnt_r - CW'(1))];
endmodule : pri_level_stack
`default_nettype wire

/* test/pri_cpu_model.sv */
// CPU core stand-in: acknowledges requests after a set delay and issues returns
`timescale 1ns/10ps
`default_nettype none
module pri_cpu_model (
   input  wire logic                       clk,
   input  wire logic                       rst,
   input  wire logic                       irq,
   input  wire logic [pri_pkg::VEC_W-1:0]  vector,
   input  wire logic                       auto_ack,
   input  wire logic [3:0]                 ack_wait,
   input  wire logic                       ret_req,
   output logic                            ack,
   output logic                            ret,
   output logic      [pri_pkg::VEC_W-1:0]  taken_vec
);
   import pri_pkg::*;
   logic [3:0] wait_r;
   ////////////////////////////////////////////////////////////////////////////////
   // Flag clearing is the handler's job; the bench does it over the register bus
   // Guard on ack stops a second pulse while the request is still falling
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wait_r    <= 4'h0;
         ack       <= 1'b0;
         taken_vec <= 7'h00;
      end
      else
      begin
         ack <= 1'b0;
         if (auto_ack && irq && !ack)
         begin
            if (wait_r >= ack_wait)
            begin
               ack       <= 1'b1;
               taken_vec <= vector;
               wait_r    <= 4'h0;
            end
            else
               wait_r <= wait_r + 4'h1;
         end
         else
            wait_r <= 4'h0;
      end
   end
   // Return only when the handler asks, one cycle after ret_req; nothing blocks the ack cycle
   always_ff @(posedge clk)
   begin
      if (rst)
         ret <= 1'b0;
      else
         ret <= ret_req;
   end
endmodule : pri_cpu_model
`default_nettype wire

/* test/priority_interrupt_controller_tb.sv */
// Self-checking bench for the priority interrupt controller
`timescale 1ns/10ps
`default_nettype none
module priority_interrupt_controller_tb;
   import pri_pkg::*;
   logic        clk, rst, wr, rd, cpu_irq, cpu_ack, cpu_return, irq_line;
   logic        auto_ack, ret_req;
   logic [7:0]  addr, src_event;
   logic [15:0] wdata, rdata, d;
   logic [3:0]  trap_event, cpu_level, ack_wait;
   logic [6:0]  cpu_vector, taken_vec;
   int          n_fail, checks, cycles;
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   pri_ctrl #(.NUM_SRC(8), .NUM_TRAP(4), .STACK_DEPTH(16)) DUT (
      .REF_CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
      .RDATA(rdata), .SRC_EVENT(src_event), .TRAP_EVENT(trap_event), .CPU_IRQ(cpu_irq),
      .CPU_VECTOR(cpu_vector), .CPU_LEVEL(cpu_level), .CPU_ACK(cpu_ack),
      .CPU_RETURN(cpu_return), .INT(irq_line));
   pri_cpu_model u_cpu (
      .clk(clk), .rst(rst), .irq(cpu_irq), .vector(cpu_vector), .auto_ack(auto_ack),
      .ack_wait(ack_wait), .ret_req(ret_req), .ack(cpu_ack), .ret(cpu_return),
      .taken_vec(taken_vec));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : test_done
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
      checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask : chk
   task automatic wr_reg(input logic [7:0] a, input logic [15:0] v);
      @(posedge clk);
      addr  <= a;
      wdata <= v;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   // Read data appears in the cycle after the strobe and holds until the next read
   task automatic rd_reg(input logic [7:0] a);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : rd_reg
   task automatic pulse(input logic [7:0] s, input logic [3:0] t);
      @(posedge clk);
      src_event  <= s;
      trap_event <= t;
      @(posedge clk);
      src_event  <= 8'h00;
      trap_event <= 4'h0;
   endtask : pulse
   task automatic settle();
      repeat (8) @(posedge clk);
      #1;
   endtask : settle
   task automatic do_ret();
      @(posedge clk);
      ret_req <= 1'b1;
      @(posedge clk);
      ret_req <= 1'b0;
      settle();
   endtask : do_ret
   function automatic logic [15:0] tst(logic u, logic h, logic [3:0] l, logic [6:0] v);
      return {u, 1'b0, h, 1'b0, l, 1'b0, v};
   endfunction : tst
   function automatic logic [15:0] cpu_out();
      return {4'h0, cpu_irq, cpu_vector, cpu_level};
   endfunction : cpu_out
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      rd_reg(8'h22); chk(d, 16'h0000, "test reg reset");
      rd_reg(8'h06); chk(d, 16'h4444, "prio reset low");
      rd_reg(8'h08); chk(d, 16'h4444, "prio reset high");
      rd_reg(8'h40); chk(d, 16'h0000, "unmapped read");
      wr_reg(8'h22, 16'hFFFF);
      rd_reg(8'h22); chk(d, 16'h2000, "test reg write mask");
      wr_reg(8'h22, 16'h0000);
      $display("t_regs done");
   endtask : t_regs
   task automatic t_gate();
      pulse(8'h01, 4'h0);
      settle(); chk(cpu_out() & 16'h0800, 16'h0000, "flag without enable");
      rd_reg(8'h02); chk(d, 16'h0001, "flag stored");
      wr_reg(8'h04, 16'h0001); settle();
      chk(cpu_out(), {4'h0, 1'b1, 7'h08, 4'h4}, "enabled request");
      wr_reg(8'h06, 16'h4440); settle();
      chk(cpu_out() & 16'h0800, 16'h0000, "priority zero");
      wr_reg(8'h06, 16'h4447); settle();
      chk(cpu_out(), {4'h0, 1'b1, 7'h08, 4'h7}, "priority seven");
      wr_reg(8'h02, 16'h0000); wr_reg(8'h06, 16'h4444);
      $display("t_gate done");
   endtask : t_gate
   task automatic t_ack_ret();
      rd_reg(8'h24);
      wr_reg(8'h26, 16'h0001); wr_reg(8'h04, 16'h000C);
      ack_wait <= 4'h3; auto_ack <= 1'b1;
      pulse(8'h0C, 4'h0); #1;
      chk(cpu_out(), {4'h0, 1'b1, 7'h0A, 4'h4}, "tie to lower vector");
      settle(); chk({9'h0, taken_vec}, 16'h000A, "vector taken");
      rd_reg(8'h22); chk(d, tst(1'b1, 1'b0, 4'h4, 7'h0A), "after ack");
      chk({15'h0, irq_line}, 16'h0001, "interrupt line up");
      rd_reg(8'h24); chk(d & 16'h0001, 16'h0001, "taken event");
      chk({15'h0, irq_line}, 16'h0000, "status cleared by read");
      wr_reg(8'h02, 16'h0008);
      wr_reg(8'h22, 16'h2000);
      rd_reg(8'h22); chk(d, tst(1'b1, 1'b1, 4'h4, 7'h0B), "hold shows pending");
      wr_reg(8'h22, 16'h0000); auto_ack <= 1'b0;
      do_ret();
      rd_reg(8'h22); chk(d, tst(1'b0, 1'b0, 4'h0, 7'h0A), "level restored");
      chk(cpu_out(), {4'h0, 1'b1, 7'h0B, 4'h4}, "left flag requests again");
      wr_reg(8'h02, 16'h0000); wr_reg(8'h04, 16'h0000); wr_reg(8'h26, 16'h0000);
      $display("t_ack_ret done");
   endtask : t_ack_ret
   task automatic t_nest();
      wr_reg(8'h06, 16'h4463); wr_reg(8'h04, 16'h0003); wr_reg(8'h00, 16'h8000);
      ack_wait <= 4'h0; auto_ack <= 1'b1;
      pulse(8'h01, 4'h0); settle();
      rd_reg(8'h22); chk(d, tst(1'b1, 1'b0, 4'h3, 7'h08), "first handler");
      wr_reg(8'h02, 16'h0000);
      pulse(8'h02, 4'h0); settle();
      rd_reg(8'h22); chk(d, tst(1'b1, 1'b0, 4'h3, 7'h08), "no nesting");
      pulse(8'h00, 4'h2); settle();
      rd_reg(8'h22); chk(d, tst(1'b1, 1'b0, 4'hE, 7'h01), "trap nests");
      wr_reg(8'h00, 16'h8000); auto_ack <= 1'b0;
      do_ret();
      rd_reg(8'h22); chk(d, tst(1'b1, 1'b0, 4'h3, 7'h01), "back in handler");
      do_ret();
      chk(cpu_out(), {4'h0, 1'b1, 7'h09, 4'h6}, "held source released");
      wr_reg(8'h00, 16'h0000); wr_reg(8'h02, 16'h0000); wr_reg(8'h06, 16'h4444);
      $display("t_nest done");
   endtask : t_nest
   task automatic t_srl();
      wr_reg(8'h06, 16'h4447); wr_reg(8'h04, 16'h0001); wr_reg(8'h20, 16'h000E);
      ack_wait <= 4'h1; auto_ack <= 1'b1;
      rd_reg(8'h22); chk(d, tst(1'b0, 1'b0, 4'h7, 7'h01), "level seven");
      pulse(8'h01, 4'h0); settle();
      chk(cpu_out() & 16'h0800, 16'h0000, "user masked");
      pulse(8'h00, 4'h1); settle();
      rd_reg(8'h22); chk(d, tst(1'b1, 1'b0, 4'hF, 7'h00), "trap unmasked");
      rd_reg(8'h24); chk(d, 16'h0007, "events held");
      rd_reg(8'h24); chk(d, 16'h0000, "events cleared");
      wr_reg(8'h00, 16'h0000); auto_ack <= 1'b0;
      do_ret();
      rd_reg(8'h20); chk(d, 16'h000E, "status byte restored");
      wr_reg(8'h20, 16'h0000); @(posedge clk); #1;
      chk(cpu_out(), {4'h0, 1'b1, 7'h08, 4'h7}, "user unmasked");
      wr_reg(8'h02, 16'h0000); wr_reg(8'h06, 16'h4444);
      $display("t_srl done");
   endtask : t_srl
   task automatic t_timed_interrupt_disable();
      pulse(8'h01, 4'h0);
      wr_reg(8'h28, 16'h0028);
      for (int p = 1; p <= 7; p++)
      begin
         wr_reg(8'h06, {12'h444, 1'b0, p[2:0]}); @(posedge clk); #1;
         chk({15'h0, cpu_irq}, {15'h0, p == 7}, "timed disable");
      end
      repeat (40) @(posedge clk);
      wr_reg(8'h06, 16'h4446); @(posedge clk); #1;
      chk({15'h0, cpu_irq}, 16'h0001, "timed disable expired");
      wr_reg(8'h02, 16'h0000); wr_reg(8'h04, 16'h0000); wr_reg(8'h06, 16'h4444);
      $display("t_timed_interrupt_disable done");
   endtask : t_timed_interrupt_disable
   ////////////////////////////////////////////////////////////////////////////////
   // Ceiling well above the few hundred cycles the tests need
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         n_fail++;
         test_done();
      end
   end
   initial
   begin
      rst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 16'h0000;
      src_event = 8'h00; trap_event = 4'h0; auto_ack = 1'b0; ack_wait = 4'h0;
      ret_req = 1'b0; n_fail = 0; checks = 0; cycles = 0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_gate();
      t_ack_ret();
      t_nest();
      t_srl();
      t_timed_interrupt_disable();
      test_done();
   end
endmodule : priority_interrupt_controller_tb
`default_nettype wire
